//--- common/udr_pkg.sv
// udr_pkg: register map, field positions and command types for the dual-role controller's driver
// assumes a 32-bit word register port on the device side, word addresses
package udr_pkg;
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 32;
  // register word addresses of the device; layout arbitrary but fixed
  localparam logic [11:0] USB_CONFIG_REG = 12'h003;
  localparam logic [11:0] GLOBAL_IRQ_STATUS_REG = 12'h005;
  localparam logic [11:0] GLOBAL_IRQ_MASK_REG = 12'h006;
  localparam logic [11:0] RESET_CONTROL_REG = 12'h004;
  localparam logic [11:0] GLOBAL_CORE_CFG_REG = 12'h00e;
  localparam logic [11:0] GLOBAL_AHB_CFG_REG = 12'h002;
  localparam logic [11:0] RX_FIFO_SIZE_REG = 12'h009;
  localparam logic [11:0] TX0_FIFO_SIZE_REG = 12'h00a;
  localparam logic [11:0] PERIODIC_FIFO_SIZE_REG = 12'h040;
  localparam logic [11:0] IN_TX_FIFO_BASE_REG = 12'h041;
  localparam logic [11:0] POWER_CLOCK_GATE_REG = 12'h380;
  // field positions
  localparam int unsigned FORCE_HOST_ROLE_BIT = 29;
  localparam int unsigned FORCE_DEVICE_ROLE_BIT = 30;
  localparam int unsigned CURRENT_ROLE_BIT = 0;
  localparam int unsigned RX_FIFO_FLUSH_BIT = 4;
  localparam int unsigned TX_FIFO_FLUSH_BIT = 5;
  localparam int unsigned TX_FIFO_SELECT_LSB = 6;
  localparam int unsigned GLOBAL_IRQ_EN_BIT = 0;
  localparam int unsigned RX_LEVEL_IRQ_MASK_BIT = 4;
  localparam int unsigned OTG_IRQ_MASK_BIT = 2;
  localparam int unsigned MODE_MISMATCH_MASK_BIT = 1;
  localparam int unsigned PHY_LOW_POWER_BIT = 17;
  localparam int unsigned TRANSCEIVER_POWER_ON_BIT = 16;
  localparam int unsigned FRAME_PULSE_OUT_EN_BIT = 20;
  localparam int unsigned STOP_PHY_CLOCK_BIT = 0;
  localparam int unsigned DEPTH_LSB = 16;
  // values
  localparam logic [4:0] TX_FIFO_SELECT_ALL = 5'h10;
  localparam logic [15:0] SRAM_WORDS = 16'h0140; // 1280 bytes
  localparam logic [15:0] SETUP_RESERVE_WORDS = 16'h000d;
  localparam logic [15:0] DEV_STATUS_WORDS = 16'h0001;
  localparam logic [15:0] HOST_STATUS_WORDS = 16'h0002;
  localparam logic [15:0] GLOBAL_NAK_WORDS = 16'h0001;
  localparam logic [2:0] IN_ENDPOINTS = 3'h3;
  localparam logic [2:0] OUT_ENDPOINTS = 3'h3;
  localparam logic [3:0] HOST_CHANNELS = 4'h8;
  localparam logic [15:0] TIMEOUT_TURNAROUND = 16'h1407; // arbitrary timing defaults
  localparam logic [15:0] POLL_LIMIT = 16'hffff;

  typedef enum logic [1:0] {UDR_OP_INIT, UDR_OP_ALLOC, UDR_OP_POWER, UDR_OP_NONE} udr_op_e;

  typedef struct packed {
    udr_op_e op;
    logic host_role;      // role to force and size for
    logic [15:0] max_pkt; // largest packet bytes
    logic [15:0] tx0_depth;
    logic [15:0] tx1_depth;
    logic [15:0] tx2_depth;
    logic [15:0] tx3_depth;
    logic low_power;
    logic stop_clock;
    logic frame_pulse_en;
  } udr_cmd_s;

  typedef struct packed {
    logic write;
    logic [11:0] addr;
    logic [31:0] wdata;
  } udr_bus_req_s;
endpackage : udr_pkg

//--- rtl/udr_host_ctrl.sv
// udr_host_ctrl: drives the dual-role controller's register port through init, fifo split and flush
// assumes the device answers each register access with rsp_valid, any number of cycles later
`timescale 1ns/1ns
`default_nettype none
// Notes on behaviour
// - system supplies 48MHz within 0.25 percent
// - bus clock above 30MHz when enabled
// - init: irq enable, levels, masks, timing
// - endpoints disabled and nakking before reallocation
// - rx fifo reserves 13 setup words
// - rx fifo reserves nak and disable words
// - rx fifo holds packet/4 plus 1
// - isochronous: two packet spaces recommended
// - each tx fifo at least packet size
// - rx lowest, tx fifos stacked above
// - select all tx, flush both fifos
// - nothing else until flush bits clear
// - host: channels off, fifos empty, flush
// - host rx: packet/4 plus 2 words
// - host periodic above nonperiodic fifo
module udr_host_ctrl (
  input wire logic core_clk, // system keeps this bus clock above 30MHz
  input wire logic rst,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire udr_pkg::udr_cmd_s cmd,
  output logic done,
  output logic error,
  output logic current_role,
  output logic req_valid,
  input wire logic req_ready,
  output udr_pkg::udr_bus_req_s req,
  input wire logic rsp_valid,
  input wire logic [31:0] rsp_rdata
);
  typedef enum logic [3:0] {S_IDLE, S_ISSUE, S_WAIT, S_POLL, S_DONE} udr_state_e;
  localparam logic [3:0] LAST_INIT = 4'h5;
  localparam logic [3:0] LAST_ALLOC = 4'h6;
  localparam logic [3:0] LAST_HOST_ALLOC = 4'h4;
  localparam logic [3:0] LAST_POWER = 4'h2;

  udr_state_e state_reg;
  udr_pkg::udr_cmd_s cmd_reg;
  logic [3:0] step_reg;
  logic [15:0] poll_reg;
  logic [15:0] rx_depth;
  logic [15:0] pkt_words;
  logic [15:0] start1;
  logic [15:0] start2;
  logic [15:0] start3;
  logic [15:0] start4;
  logic [3:0] last_step;
  udr_pkg::udr_bus_req_s step_req;
  logic poll_step;
  // two-entry request buffer
  udr_pkg::udr_bus_req_s buf_mem [2];
  logic buf_wr_reg;
  logic buf_rd_reg;
  logic [1:0] buf_cnt_reg;
  logic push;
  logic pop;

  // rx depth from packet size plus status and reserved words
  always_comb begin
    pkt_words = cmd_reg.max_pkt >> 2;
    if (cmd_reg.host_role) begin
      rx_depth = 16'((pkt_words + udr_pkg::HOST_STATUS_WORDS) << 1);
    end else begin
      rx_depth = 16'(udr_pkg::SETUP_RESERVE_WORDS + udr_pkg::GLOBAL_NAK_WORDS
        + 16'(udr_pkg::OUT_ENDPOINTS) + ((pkt_words + udr_pkg::DEV_STATUS_WORDS) << 1));
    end
    start1 = 16'(rx_depth + cmd_reg.tx0_depth);
    start2 = 16'(start1 + cmd_reg.tx1_depth);
    start3 = 16'(start2 + cmd_reg.tx2_depth);
    start4 = 16'(start3 + cmd_reg.tx3_depth); // checked against sram size
  end

  always_comb begin
    case (cmd_reg.op)
      udr_pkg::UDR_OP_INIT: last_step = LAST_INIT;
      udr_pkg::UDR_OP_ALLOC: last_step = cmd_reg.host_role ? LAST_HOST_ALLOC : LAST_ALLOC;
      udr_pkg::UDR_OP_POWER: last_step = LAST_POWER;
      default: last_step = 4'h0;
    endcase
  end

  // per-step register access; step 5 of init is a read of role status
  always_comb begin
    step_req = '0;
    poll_step = 1'b0;
    case (cmd_reg.op)
      udr_pkg::UDR_OP_INIT: begin
        step_req.write = 1'b1;
        case (step_reg)
          4'h0: begin
            step_req.addr = udr_pkg::GLOBAL_AHB_CFG_REG;
            step_req.wdata[udr_pkg::GLOBAL_IRQ_EN_BIT] = 1'b1;
          end
          4'h1: step_req.addr = udr_pkg::GLOBAL_IRQ_MASK_REG; // rx level mask 0
          4'h2: begin
            step_req.addr = udr_pkg::USB_CONFIG_REG;
            step_req.wdata[15:0] = udr_pkg::TIMEOUT_TURNAROUND;
            step_req.wdata[udr_pkg::FORCE_HOST_ROLE_BIT] = cmd_reg.host_role;
            step_req.wdata[udr_pkg::FORCE_DEVICE_ROLE_BIT] = ~cmd_reg.host_role;
          end
          4'h3: begin
            step_req.addr = udr_pkg::GLOBAL_IRQ_MASK_REG;
            step_req.wdata[udr_pkg::OTG_IRQ_MASK_BIT] = 1'b1;
            step_req.wdata[udr_pkg::MODE_MISMATCH_MASK_BIT] = 1'b1;
          end
          4'h4: begin
            step_req.addr = udr_pkg::GLOBAL_CORE_CFG_REG;
            step_req.wdata[udr_pkg::TRANSCEIVER_POWER_ON_BIT] = 1'b1;
            step_req.wdata[udr_pkg::FRAME_PULSE_OUT_EN_BIT] = cmd_reg.frame_pulse_en;
          end
          default: begin
            step_req.write = 1'b0;
            step_req.addr = udr_pkg::GLOBAL_IRQ_STATUS_REG;
          end
        endcase
      end
      udr_pkg::UDR_OP_ALLOC: begin
        step_req.write = 1'b1;
        case (step_reg)
          4'h0: begin
            step_req.addr = udr_pkg::RX_FIFO_SIZE_REG;
            step_req.wdata[15:0] = rx_depth;
          end
          4'h1: step_req.addr = udr_pkg::TX0_FIFO_SIZE_REG;
          4'h2: step_req.addr = cmd_reg.host_role ? udr_pkg::PERIODIC_FIFO_SIZE_REG : udr_pkg::IN_TX_FIFO_BASE_REG;
          4'h3: step_req.addr = 12'(udr_pkg::IN_TX_FIFO_BASE_REG + 12'h001);
          4'h4: step_req.addr = 12'(udr_pkg::IN_TX_FIFO_BASE_REG + 12'h002);
          default: begin
            step_req.addr = udr_pkg::RESET_CONTROL_REG;
            step_req.wdata[udr_pkg::TX_FIFO_SELECT_LSB +: 5] = udr_pkg::TX_FIFO_SELECT_ALL;
            step_req.wdata[udr_pkg::TX_FIFO_FLUSH_BIT] = 1'b1;
            step_req.wdata[udr_pkg::RX_FIFO_FLUSH_BIT] = 1'b1;
          end
        endcase
        case (step_reg)
          4'h1: step_req.wdata = {cmd_reg.tx0_depth, rx_depth};
          4'h2: step_req.wdata = {cmd_reg.tx1_depth, start1};
          4'h3: step_req.wdata = {cmd_reg.tx2_depth, start2};
          4'h4: step_req.wdata = cmd_reg.host_role ? step_req.wdata : {cmd_reg.tx3_depth, start3};
          default: ;
        endcase
        if (step_reg == last_step) begin
          step_req.addr = udr_pkg::RESET_CONTROL_REG; // host poll step would otherwise read a tx size word
          step_req.write = 1'b0;
          step_req.wdata = '0;
          poll_step = 1'b1;
        end
        if (cmd_reg.host_role && step_reg == 4'h3) begin
          step_req.addr = udr_pkg::RESET_CONTROL_REG;
          step_req.wdata = '0;
          step_req.wdata[udr_pkg::TX_FIFO_SELECT_LSB +: 5] = udr_pkg::TX_FIFO_SELECT_ALL;
          step_req.wdata[udr_pkg::TX_FIFO_FLUSH_BIT] = 1'b1;
          step_req.wdata[udr_pkg::RX_FIFO_FLUSH_BIT] = 1'b1;
        end
        if (!cmd_reg.host_role && step_reg >= 4'h5 && step_reg < last_step) begin
          step_req.addr = udr_pkg::RESET_CONTROL_REG;
          step_req.wdata = '0;
          step_req.wdata[udr_pkg::TX_FIFO_SELECT_LSB +: 5] = udr_pkg::TX_FIFO_SELECT_ALL;
          step_req.wdata[udr_pkg::TX_FIFO_FLUSH_BIT] = 1'b1;
          step_req.wdata[udr_pkg::RX_FIFO_FLUSH_BIT] = 1'b1;
        end
      end
      udr_pkg::UDR_OP_POWER: begin
        step_req.write = 1'b1;
        case (step_reg)
          4'h0: begin
            step_req.addr = udr_pkg::GLOBAL_CORE_CFG_REG;
            step_req.wdata[udr_pkg::PHY_LOW_POWER_BIT] = cmd_reg.low_power;
            step_req.wdata[udr_pkg::TRANSCEIVER_POWER_ON_BIT] = 1'b1;
            step_req.wdata[udr_pkg::FRAME_PULSE_OUT_EN_BIT] = cmd_reg.frame_pulse_en;
          end
          4'h1: begin
            step_req.addr = udr_pkg::POWER_CLOCK_GATE_REG;
            step_req.wdata[udr_pkg::STOP_PHY_CLOCK_BIT] = cmd_reg.stop_clock;
          end
          default: begin
            step_req.write = 1'b0;
            step_req.addr = udr_pkg::GLOBAL_IRQ_STATUS_REG;
          end
        endcase
      end
      default: ;
    endcase
  end

  assign cmd_ready = (state_reg == S_IDLE);
  assign push = (state_reg == S_ISSUE) && (buf_cnt_reg != 2'h2);
  assign pop = req_valid && req_ready;
  assign req_valid = (buf_cnt_reg != 2'h0);
  assign req = buf_mem[buf_rd_reg];

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      buf_wr_reg <= 1'b0;
      buf_rd_reg <= 1'b0;
      buf_cnt_reg <= 2'h0;
    end else begin
      if (push) begin
        buf_wr_reg <= ~buf_wr_reg;
      end
      if (pop) begin
        buf_rd_reg <= ~buf_rd_reg;
      end
      buf_cnt_reg <= 2'(buf_cnt_reg + {1'b0, push} - {1'b0, pop});
    end
  end

  always_ff @(posedge core_clk) begin
    if (push) begin
      buf_mem[buf_wr_reg] <= step_req;
    end
  end

  // sequencer: one access at a time, waits for each answer
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_reg <= S_IDLE;
      step_reg <= 4'h0;
      poll_reg <= 16'h0000;
      cmd_reg <= '0;
      done <= 1'b0;
      error <= 1'b0;
    end else begin
      done <= 1'b0;
      case (state_reg)
        S_IDLE: begin
          if (cmd_valid && cmd.op != udr_pkg::UDR_OP_NONE) begin
            cmd_reg <= cmd; // caller keeps endpoints and channels off before alloc
            step_reg <= 4'h0;
            poll_reg <= 16'h0000;
            error <= 1'b0;
            state_reg <= S_ISSUE;
          end
        end
        S_ISSUE: begin
          if (push) begin
            state_reg <= poll_step ? S_POLL : S_WAIT;
          end
        end
        S_WAIT: begin
          if (rsp_valid) begin
            if (step_reg == 4'h0 && cmd_reg.op == udr_pkg::UDR_OP_ALLOC && start4 > udr_pkg::SRAM_WORDS) begin
              error <= 1'b1;
            end
            step_reg <= 4'(step_reg + 4'h1);
            state_reg <= (step_reg == last_step) ? S_DONE : S_ISSUE;
          end
        end
        S_POLL: begin
          if (rsp_valid) begin
            if (!rsp_rdata[udr_pkg::TX_FIFO_FLUSH_BIT] && !rsp_rdata[udr_pkg::RX_FIFO_FLUSH_BIT]) begin
              state_reg <= S_DONE;
            end else if (poll_reg == udr_pkg::POLL_LIMIT) begin
              error <= 1'b1;
              state_reg <= S_DONE;
            end else begin
              poll_reg <= 16'(poll_reg + 16'h0001);
              state_reg <= S_ISSUE;
            end
          end
        end
        S_DONE: begin
          done <= 1'b1;
          state_reg <= S_IDLE;
        end
        default: state_reg <= S_IDLE;
      endcase
    end
  end

  // role status captured from last status read
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      current_role <= 1'b0;
    end else if (state_reg == S_WAIT && rsp_valid && step_reg == last_step && !req_valid) begin
      current_role <= rsp_rdata[udr_pkg::CURRENT_ROLE_BIT];
    end
  end
endmodule : udr_host_ctrl
`default_nettype wire

//--- test/testbench.sv
// testbench: init, fifo split, overflow and power commands against the device model
// assumes udr_dev_model stands on the register port
`timescale 1ns/1ns
`default_nettype none
module testbench;
  logic core_clk, rst, cmd_valid, cmd_ready, done, error, current_role, req_valid, req_ready, rsp_valid, slow;
  udr_pkg::udr_cmd_s cmd;
  udr_pkg::udr_bus_req_s req;
  logic [31:0] rsp_rdata;
  int fails, comparisons;
  udr_host_ctrl i_udr_host_ctrl (.core_clk(core_clk), .rst(rst), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .cmd(cmd), .done(done), .error(error), .current_role(current_role), .req_valid(req_valid),
    .req_ready(req_ready), .req(req), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata));
  udr_dev_model i_udr_dev_model (.core_clk(core_clk), .rst(rst), .slow(slow), .plug_host(1'b0),
    .req_valid(req_valid), .req_ready(req_ready), .req(req), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic end_of_test;
    $display("fails=%0d comparisons=%0d", fails, comparisons);
    if (fails == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : end_of_test
  task automatic go(input udr_pkg::udr_op_e op, input logic h, input logic [15:0] p, d0, d1, d2, d3,
      input logic lp, sc, fp);
    int n;
    n = 0;
    @(posedge core_clk);
    cmd <= '{op, h, p, d0, d1, d2, d3, lp, sc, fp};
    cmd_valid <= 1'b1;
    @(negedge core_clk);
    while (cmd_ready !== 1'b1 && n < 100) begin @(negedge core_clk); n++; end
    @(posedge core_clk);
    cmd_valid <= 1'b0;
    n = 0;
    while (done !== 1'b1 && n < 5000) begin @(negedge core_clk); n++; end
    check(n < 5000, 1'b1);
  endtask : go
  task automatic t_init(input logic h);
    go(udr_pkg::UDR_OP_INIT, h, 16'h0040, 16'h0, 16'h0, 16'h0, 16'h0, 1'b0, 1'b0, 1'b1);
    check(current_role, h);
    check(i_udr_dev_model.regs[udr_pkg::USB_CONFIG_REG][30:29], h ? 2'h1 : 2'h2);
    check(i_udr_dev_model.regs[udr_pkg::GLOBAL_AHB_CFG_REG][0], 1'b1);
    check(i_udr_dev_model.regs[udr_pkg::GLOBAL_IRQ_MASK_REG][4:1], 4'h3);
    check(i_udr_dev_model.regs[udr_pkg::GLOBAL_CORE_CFG_REG][20], 1'b1);
    check(i_udr_dev_model.regs[udr_pkg::GLOBAL_CORE_CFG_REG][16], 1'b1);
  endtask : t_init
  task automatic t_alloc(input logic h, input logic [15:0] p, d0, d1, d2, d3);
    logic [15:0] rx;
    rx = h ? 16'h0002 * (p / 16'h0004 + 16'h0002) : 16'h0011 + 16'h0002 * (p / 16'h0004 + 16'h0001);
    go(udr_pkg::UDR_OP_ALLOC, h, p, d0, d1, d2, d3, 1'b0, 1'b0, 1'b0);
    check(i_udr_dev_model.regs[udr_pkg::RX_FIFO_SIZE_REG][15:0], rx);
    check(i_udr_dev_model.regs[udr_pkg::TX0_FIFO_SIZE_REG], {d0, rx});
    if (h) check(i_udr_dev_model.regs[udr_pkg::PERIODIC_FIFO_SIZE_REG], {d1, rx + d0});
    else begin
      check(i_udr_dev_model.regs[udr_pkg::IN_TX_FIFO_BASE_REG], {d1, rx + d0});
      check(i_udr_dev_model.regs[12'h043], {d3, rx + d0 + d1 + d2});
    end
    check(i_udr_dev_model.regs[udr_pkg::RESET_CONTROL_REG][10:4], 7'h43);
    check(i_udr_dev_model.flush_reg, 4'h0);
    check(error, 1'b0);
  endtask : t_alloc
  task automatic t_power(input logic lp, input logic sc);
    go(udr_pkg::UDR_OP_POWER, 1'b0, 16'h0040, 16'h0, 16'h0, 16'h0, 16'h0, lp, sc, 1'b1);
    check(i_udr_dev_model.regs[udr_pkg::GLOBAL_CORE_CFG_REG][17], lp);
    check(i_udr_dev_model.regs[udr_pkg::POWER_CLOCK_GATE_REG][0], sc);
    check(error, 1'b0);
    check(current_role, 1'b1);
  endtask : t_power
  task automatic t_over;
    go(udr_pkg::UDR_OP_ALLOC, 1'b0, 16'h0040, 16'h0100, 16'h0010, 16'h0010, 16'h0010, 1'b0, 1'b0, 1'b0);
    check(error, 1'b1);
    repeat (3) @(negedge core_clk);
    check(error, 1'b1);
  endtask : t_over
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  initial begin
    #500000;
    fails++;
    end_of_test();
  end
  initial begin
    rst = 1'b1;
    cmd_valid = 1'b0;
    cmd = '0;
    slow = 1'b0;
    fails = 0;
    comparisons = 0;
    repeat (12) @(posedge core_clk);
    rst <= 1'b0;
    @(negedge core_clk);
    check({cmd_ready, done, error, req_valid, current_role}, 5'h10);
    t_init(1'b0);
    t_alloc(1'b0, 16'h0040, 16'h0010, 16'h0011, 16'h0012, 16'h0013);
    slow <= 1'b1; // stalls each register access four cycles
    t_init(1'b1);
    t_alloc(1'b1, 16'h0040, 16'h0020, 16'h0018, 16'h0, 16'h0);
    t_over();
    t_power(1'b1, 1'b1);
    t_power(1'b0, 1'b0);
    end_of_test();
  end
endmodule : testbench
`default_nettype wire

//--- test/udr_dev_model.sv
// udr_dev_model: register side of the dual-role controller, answers one access at a time
// assumes the driver holds each request until req_ready and waits for rsp_valid
`timescale 1ns/1ns
`default_nettype none
module udr_dev_model (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic slow,
  input wire logic plug_host,
  input wire logic req_valid,
  output logic req_ready,
  input wire udr_pkg::udr_bus_req_s req,
  output logic rsp_valid,
  output logic [31:0] rsp_rdata
);
  logic [31:0] regs [0:4095];
  logic [3:0] wait_reg;
  logic [3:0] flush_reg;
  logic [31:0] last_reg;
  logic [31:0] rd;
  logic [31:0] cfg;
  // slow mode stalls four cycles per access
  assign req_ready = req_valid && (!slow || wait_reg == 4'h4);
  assign cfg = regs[udr_pkg::USB_CONFIG_REG];
  always_comb begin
    rd = regs[req.addr];
    if (req.addr == udr_pkg::RESET_CONTROL_REG) rd[5:4] = {2{flush_reg != 4'h0}};
    if (req.addr == udr_pkg::GLOBAL_IRQ_STATUS_REG) rd = {31'h0, cfg[29] | (!cfg[30] && plug_host)};
  end
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      wait_reg <= 4'h0;
      flush_reg <= 4'h0;
      rsp_valid <= 1'b0;
      rsp_rdata <= 32'h0;
      last_reg <= 32'h0;
    end else begin
      rsp_valid <= 1'b0;
      rsp_rdata <= ~last_reg; // idle data is not the last answer
      if (flush_reg != 4'h0) flush_reg <= flush_reg - 4'h1;
      if (req_valid && !req_ready) wait_reg <= wait_reg + 4'h1;
      if (req_valid && req_ready) begin
        wait_reg <= 4'h0;
        rsp_valid <= 1'b1;
        rsp_rdata <= rd;
        last_reg <= rd;
        if (req.write) regs[req.addr] <= req.wdata;
        if (req.write && req.addr == udr_pkg::RESET_CONTROL_REG && req.wdata[5:4] != 2'h0) flush_reg <= 4'hf;
      end
    end
  end
endmodule : udr_dev_model
`default_nettype wire

//--- test/udr_host_chk.sv
// udr_host_chk: port-level checks of the controller driver
// assumes one clock and the device map of the package
`timescale 1ns/1ns
`default_nettype none
module udr_host_chk (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic cmd_valid,
  input wire logic cmd_ready,
  input wire udr_pkg::udr_cmd_s cmd,
  input wire logic done,
  input wire logic error,
  input wire logic current_role,
  input wire logic req_valid,
  input wire logic req_ready,
  input wire udr_pkg::udr_bus_req_s req,
  input wire logic rsp_valid,
  input wire logic [31:0] rsp_rdata
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  logic wr;
  logic take;
  logic out_reg;
  logic [15:0] rx_reg;
  logic [31:0] prev_reg;
  assign wr = req_valid && req_ready && req.write;
  assign take = cmd_valid && cmd_ready && cmd.op != udr_pkg::UDR_OP_NONE;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      out_reg <= 1'b0;
      rx_reg <= 16'h0;
      prev_reg <= 32'h0;
    end else begin
      if (req_valid && req_ready) out_reg <= 1'b1;
      else if (rsp_valid) out_reg <= 1'b0;
      if (wr && req.addr == udr_pkg::RX_FIFO_SIZE_REG) rx_reg <= req.wdata[15:0];
      if (wr && (req.addr == udr_pkg::TX0_FIFO_SIZE_REG || req.addr == udr_pkg::PERIODIC_FIFO_SIZE_REG
          || req.addr inside {[12'h041:12'h043]})) prev_reg <= req.wdata;
    end
  end
  req_hold_a: assert property (req_valid && !req_ready |=> req_valid && $stable(req))
    else $error("request changed before ready");
  one_out_a: assert property (out_reg |-> !req_valid)
    else $error("second request before answer");
  done_pulse_a: assert property (done |=> !done) else $error("done longer than one cycle");
  err_hold_a: assert property (error && !(cmd_valid && cmd_ready) |=> error) else $error("error dropped early");
  first_req_a: assert property (take |-> ##2 req_valid) else $error("first request late");
  busy_cmd_a: assert property (take |=> !cmd_ready) else $error("command port open while busy");
  flush_word_a: assert property (wr && req.addr == udr_pkg::RESET_CONTROL_REG |->
    req.wdata[10:6] == udr_pkg::TX_FIFO_SELECT_ALL && req.wdata[5:4] == 2'h3)
    else $error("flush word wrong");
  force_one_a: assert property (wr && req.addr == udr_pkg::USB_CONFIG_REG |-> req.wdata[29] != req.wdata[30])
    else $error("role force bits wrong");
  rx_mask_a: assert property (wr && req.addr == udr_pkg::GLOBAL_IRQ_MASK_REG |-> !req.wdata[4])
    else $error("rx level irq unmasked");
  tx0_start_a: assert property (wr && req.addr == udr_pkg::TX0_FIFO_SIZE_REG |-> req.wdata[15:0] == rx_reg)
    else $error("tx0 start not rx depth");
  stack_a: assert property (wr && (req.addr == udr_pkg::PERIODIC_FIFO_SIZE_REG || req.addr inside {[12'h041:12'h043]})
    |-> req.wdata[15:0] == prev_reg[15:0] + prev_reg[31:16])
    else $error("fifo start not stacked");
  host_done_c: cover property (done && current_role);
  err_c: cover property ($rose(error));
  stall_c: cover property (req_valid && !req_ready);
endmodule : udr_host_chk
bind udr_host_ctrl udr_host_chk i_udr_host_chk (.core_clk(core_clk), .rst(rst), .cmd_valid(cmd_valid),
  .cmd_ready(cmd_ready), .cmd(cmd), .done(done), .error(error), .current_role(current_role), .req_valid(req_valid),
  .req_ready(req_ready), .req(req), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata));
`default_nettype wire
